// File: verilog/modem_host_buffer.sv
// Host data buffers, DMA request pins, line coding, test pattern and frame check
module modem_host_buffer #(
	parameter int DEPTH = modem_buffer_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                                    CLK,
	input  wire logic                                    RST,
	// Configuration
	input  wire logic                                    SYNC_MODE,
	input  wire logic                                    TX_BUFFER_ENABLE,
	input  wire logic                                    DMA_ENABLE,
	input  wire logic                                    INVERTED_CODING_SELECT,
	input  wire logic                                    TEST_PATTERN_ENABLE,
	input  wire logic                                    HDLC_MODE,
	input  wire logic                                    CRC32_SELECT,
	input  wire logic                                    CRC_RESTART,
	input  wire logic [3:0]                              INT_MASK,
	// Host transmit and receive data
	input  wire logic                                    TX_WR_EN,
	input  wire logic [modem_buffer_pkg::BYTE_W-1:0]     TX_WR_DATA,
	input  wire logic                                    RX_RD_EN,
	output logic      [modem_buffer_pkg::BYTE_W-1:0]     RX_RD_DATA,
	output logic                                         RX_RD_VALID,
	// Status
	output logic                                         TX_NOT_FULL,
	output logic                                         RX_NOT_EMPTY,
	output logic                                         TX_HALF_FULL,
	output logic                                         RX_HALF_FULL,
	output logic                                         TX_BUFFER_EMPTY,
	output logic                                         RX_BUFFER_FULL,
	output logic                                         IRQ_REQUEST,
	// Shared ring and data-set-ready pins
	input  wire logic                                    RING_LEVEL_N,
	input  wire logic                                    DSR_LEVEL_N,
	output logic                                         RING_INDICATOR_OUT,
	output logic                                         DATA_SET_READY_OUT,
	// Serial line
	input  wire logic                                    BIT_TICK,
	output logic                                         TX_LINE,
	input  wire logic                                    RX_LINE,
	output logic                                         PATTERN_DETECT,
	output logic      [31:0]                             TX_FCS,
	output logic                                         RX_CRC_GOOD
);
	import modem_buffer_pkg::*;

	// ----------------------------------------
	// Buffers
	// ----------------------------------------
	logic [BYTE_W-1:0]  tx_head;
	logic [BYTE_W-1:0]  rx_head;
	logic [COUNT_W-1:0] tx_count;
	logic [COUNT_W-1:0] rx_count;
	logic [COUNT_W-1:0] tx_limit;
	logic               tx_pop;
	logic               rx_pop;
	logic               rx_push;
	logic [BYTE_W-1:0]  rx_byte;

	// Without the enable the transmit path holds a single byte only
	assign tx_limit = TX_BUFFER_ENABLE ? FULL_CAP : SINGLE_CAP;

	modem_byte_fifo #(
		.WIDTH (BYTE_W),
		.DEPTH (DEPTH),
		.CNT_W (COUNT_W)
	) u_tx_fifo (
		.clk     (CLK),
		.rst     (RST),
		.wr_en   (TX_WR_EN),
		.wr_data (TX_WR_DATA),
		.limit   (tx_limit),
		.rd_en   (tx_pop),
		.head    (tx_head),
		.count   (tx_count)
	);

	modem_byte_fifo #(
		.WIDTH (BYTE_W),
		.DEPTH (DEPTH),
		.CNT_W (COUNT_W)
	) u_rx_fifo (
		.clk     (CLK),
		.rst     (RST),
		.wr_en   (rx_push),
		.wr_data (rx_byte),
		.limit   (FULL_CAP),
		.rd_en   (rx_pop),
		.head    (rx_head),
		.count   (rx_count)
	);

	// ----------------------------------------
	// Status, interrupt and DMA pins
	// ----------------------------------------
	logic [3:0]        flags_ff;
	logic [3:0]        nxt_flags;
	logic              tx_empty_ff;
	logic              nxt_tx_empty;
	logic              rx_full_ff;
	logic              nxt_rx_full;
	logic              irq_ff;
	logic              nxt_irq;
	logic              ri_pin_ff;
	logic              nxt_ri_pin;
	logic              dsr_pin_ff;
	logic              nxt_dsr_pin;
	logic [1:0]        ring_sync_ff;
	logic [1:0]        dsr_sync_ff;
	logic [BYTE_W-1:0] rd_data_ff;
	logic [BYTE_W-1:0] nxt_rd_data;
	logic              rd_valid_ff;
	logic              nxt_rd_valid;
	logic              dma_on;

	always_comb begin
		// Flag order: tx not full, rx not empty, rx half full, tx half full
		nxt_flags[0] = tx_count < tx_limit;
		nxt_flags[1] = rx_count != '0;
		nxt_flags[2] = rx_count >= HALF_LEVEL;
		nxt_flags[3] = tx_count >= HALF_LEVEL;
		nxt_irq      = |((nxt_flags ^ flags_ff) & INT_MASK);
		nxt_tx_empty = nxt_flags[0];
		nxt_rx_full  = nxt_flags[1];
		dma_on       = DMA_ENABLE && SYNC_MODE;
		nxt_ri_pin   = dma_on ? nxt_tx_empty : ring_sync_ff[1];
		nxt_dsr_pin  = dma_on ? nxt_rx_full : dsr_sync_ff[1];
		rx_pop       = RX_RD_EN && (rx_count != '0);
		nxt_rd_data  = rx_pop ? rx_head : rd_data_ff;
		nxt_rd_valid = rx_pop;
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			flags_ff     <= 4'h1;
			tx_empty_ff  <= 1'b1;
			rx_full_ff   <= 1'b0;
			irq_ff       <= 1'b0;
			ri_pin_ff    <= 1'b1;
			dsr_pin_ff   <= 1'b1;
			ring_sync_ff <= 2'h3;
			dsr_sync_ff  <= 2'h3;
			rd_data_ff   <= '0;
			rd_valid_ff  <= 1'b0;
		end else begin
			flags_ff     <= nxt_flags;
			tx_empty_ff  <= nxt_tx_empty;
			rx_full_ff   <= nxt_rx_full;
			irq_ff       <= nxt_irq;
			ri_pin_ff    <= nxt_ri_pin;
			dsr_pin_ff   <= nxt_dsr_pin;
			ring_sync_ff <= {ring_sync_ff[0], RING_LEVEL_N};
			dsr_sync_ff  <= {dsr_sync_ff[0], DSR_LEVEL_N};
			rd_data_ff   <= nxt_rd_data;
			rd_valid_ff  <= nxt_rd_valid;
		end
	end

	assign TX_NOT_FULL        = flags_ff[0];
	assign RX_NOT_EMPTY       = flags_ff[1];
	assign RX_HALF_FULL       = flags_ff[2];
	assign TX_HALF_FULL       = flags_ff[3];
	assign TX_BUFFER_EMPTY    = tx_empty_ff;
	assign RX_BUFFER_FULL     = rx_full_ff;
	assign IRQ_REQUEST        = irq_ff;
	assign RING_INDICATOR_OUT = ri_pin_ff;
	assign DATA_SET_READY_OUT = dsr_pin_ff;
	assign RX_RD_DATA         = rd_data_ff;
	assign RX_RD_VALID        = rd_valid_ff;

	// ----------------------------------------
	// Transmit serialiser
	// ----------------------------------------
	tx_state_t         tx_state_ff;
	tx_state_t         nxt_tx_state;
	logic [BYTE_W-1:0] tx_shift_ff;
	logic [BYTE_W-1:0] nxt_tx_shift;
	logic [2:0]        tx_bits_ff;
	logic [2:0]        nxt_tx_bits;
	logic [8:0]        prbs_tx_ff;
	logic [8:0]        nxt_prbs_tx;
	logic              line_ff;
	logic              nxt_line;
	logic [31:0]       crc_tx_ff;
	logic [31:0]       nxt_crc_tx;
	logic [31:0]       fcs_ff;
	logic [31:0]       nxt_fcs;
	logic              tx_bit;
	logic              tx_data_bit;
	logic              pattern_on;
	logic              nrzi_on;

	always_comb begin
		pattern_on   = TEST_PATTERN_ENABLE && SYNC_MODE;
		nrzi_on      = INVERTED_CODING_SELECT && SYNC_MODE;
		nxt_tx_state = tx_state_ff;
		nxt_tx_shift = tx_shift_ff;
		nxt_tx_bits  = tx_bits_ff;
		nxt_prbs_tx  = prbs_tx_ff;
		nxt_line     = line_ff;
		nxt_crc_tx   = crc_tx_ff;
		tx_pop       = 1'b0;
		tx_bit       = MARK_LEVEL;
		tx_data_bit  = 1'b0;
		if (BIT_TICK) begin
			if (pattern_on) begin
				tx_bit      = prbs_next(prbs_tx_ff);
				nxt_prbs_tx = {prbs_tx_ff[7:0], tx_bit};
			end else begin
				unique case (tx_state_ff)
					TX_IDLE: begin
						if (tx_count != '0) begin
							tx_pop       = 1'b1;
							tx_bit       = tx_head[0];
							tx_data_bit  = 1'b1;
							nxt_tx_shift = {1'b0, tx_head[BYTE_W-1:1]};
							nxt_tx_bits  = LAST_BIT;
							nxt_tx_state = TX_SHIFT;
						end
					end
					TX_SHIFT: begin
						tx_bit       = tx_shift_ff[0];
						tx_data_bit  = 1'b1;
						nxt_tx_shift = {1'b0, tx_shift_ff[BYTE_W-1:1]};
						nxt_tx_bits  = tx_bits_ff - 1'b1;
						if (tx_bits_ff == 3'h1) begin
							nxt_tx_state = TX_IDLE;
						end
					end
				endcase
			end
			if (nrzi_on) begin
				nxt_line = tx_bit ? line_ff : ~line_ff;
			end else begin
				nxt_line = tx_bit;
			end
		end
		if (CRC_RESTART) begin
			nxt_crc_tx = crc_init(CRC32_SELECT);
		end else if (tx_data_bit && HDLC_MODE) begin
			nxt_crc_tx = crc_step(crc_tx_ff, tx_bit, CRC32_SELECT);
		end
		nxt_fcs = CRC32_SELECT ? ~nxt_crc_tx : (~nxt_crc_tx & CRC16_MASK);
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			tx_state_ff <= TX_IDLE;
			tx_shift_ff <= '0;
			tx_bits_ff  <= '0;
			prbs_tx_ff  <= PRBS_SEED;
			line_ff     <= MARK_LEVEL;
			crc_tx_ff   <= CRC16_INIT;
			fcs_ff      <= '0;
		end else begin
			tx_state_ff <= nxt_tx_state;
			tx_shift_ff <= nxt_tx_shift;
			tx_bits_ff  <= nxt_tx_bits;
			prbs_tx_ff  <= nxt_prbs_tx;
			line_ff     <= nxt_line;
			crc_tx_ff   <= nxt_crc_tx;
			fcs_ff      <= nxt_fcs;
		end
	end

	assign TX_LINE = line_ff;
	assign TX_FCS  = fcs_ff;

	// ----------------------------------------
	// Receive deserialiser and pattern checker
	// ----------------------------------------
	logic [1:0]        rx_sync_ff;
	logic              rx_prev_ff;
	logic              nxt_rx_prev;
	logic [BYTE_W-1:0] rx_shift_ff;
	logic [BYTE_W-1:0] nxt_rx_shift;
	logic [2:0]        rx_bits_ff;
	logic [2:0]        nxt_rx_bits;
	logic [8:0]        prbs_rx_ff;
	logic [8:0]        nxt_prbs_rx;
	logic [9:0]        lock_ff;
	logic [9:0]        nxt_lock;
	logic              detect_ff;
	logic              nxt_detect;
	logic [31:0]       crc_rx_ff;
	logic [31:0]       nxt_crc_rx;
	logic              crc_good_ff;
	logic              nxt_crc_good;
	logic              rx_bit;

	always_comb begin
		nxt_rx_prev  = rx_prev_ff;
		nxt_rx_shift = rx_shift_ff;
		nxt_rx_bits  = rx_bits_ff;
		nxt_prbs_rx  = prbs_rx_ff;
		nxt_lock     = lock_ff;
		nxt_crc_rx   = crc_rx_ff;
		rx_push      = 1'b0;
		rx_byte      = {rx_sync_ff[1], rx_shift_ff[BYTE_W-1:1]};
		rx_bit       = rx_sync_ff[1];
		if (BIT_TICK) begin
			// NRZI: unchanged level is a one
			rx_bit       = nrzi_on ? (rx_sync_ff[1] == rx_prev_ff) : rx_sync_ff[1];
			rx_byte      = {rx_bit, rx_shift_ff[BYTE_W-1:1]};
			nxt_rx_prev  = rx_sync_ff[1];
			nxt_rx_shift = rx_byte;
			nxt_rx_bits  = rx_bits_ff + 1'b1;
			rx_push      = rx_bits_ff == LAST_BIT;
			nxt_prbs_rx  = {prbs_rx_ff[7:0], rx_bit};
			if (!pattern_on || rx_bit != prbs_next(prbs_rx_ff)) begin
				nxt_lock = '0;
			end else if (lock_ff != PATTERN_PERIOD) begin
				nxt_lock = lock_ff + 1'b1;
			end
			if (HDLC_MODE) begin
				nxt_crc_rx = crc_step(crc_rx_ff, rx_bit, CRC32_SELECT);
			end
		end
		if (CRC_RESTART) begin
			nxt_crc_rx = crc_init(CRC32_SELECT);
		end
		nxt_detect   = pattern_on && (nxt_lock == PATTERN_PERIOD);
		nxt_crc_good = nxt_crc_rx == (CRC32_SELECT ? CRC32_GOOD : CRC16_GOOD);
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rx_sync_ff  <= 2'h3;
			rx_prev_ff  <= MARK_LEVEL;
			rx_shift_ff <= '0;
			rx_bits_ff  <= '0;
			prbs_rx_ff  <= '0;
			lock_ff     <= '0;
			detect_ff   <= 1'b0;
			crc_rx_ff   <= CRC16_INIT;
			crc_good_ff <= 1'b0;
		end else begin
			rx_sync_ff  <= {rx_sync_ff[0], RX_LINE};
			rx_prev_ff  <= nxt_rx_prev;
			rx_shift_ff <= nxt_rx_shift;
			rx_bits_ff  <= nxt_rx_bits;
			prbs_rx_ff  <= nxt_prbs_rx;
			lock_ff     <= nxt_lock;
			detect_ff   <= nxt_detect;
			crc_rx_ff   <= nxt_crc_rx;
			crc_good_ff <= nxt_crc_good;
		end
	end

	assign PATTERN_DETECT = detect_ff;
	assign RX_CRC_GOOD    = crc_good_ff;

endmodule // modem_host_buffer

// File: include/modem_buffer_pkg.sv
// Constants, types and helper functions for the modem host buffer block
//
// Notes on behaviour
// - One transmit and one receive buffer, each holding up to 16 bytes.
// - Receive buffer accepts bytes whenever it is not full, independent of any enable.
// - Transmit buffer buffers bytes only while its enable bit is set.
// - Each buffer flags half full whenever it holds 8 or more bytes.
// - Flags show transmit buffer has room and receive buffer holds a byte.
// - Masked interrupt request whenever any of the four buffer flags changes state.
// - DMA requests appear only while the modem is in a synchronous mode.
// - The DMA enable bit switches DMA support on and off.
// - With DMA on, ring pin carries transmit request, data-set-ready pin receive request.
// - Transmit request follows buffer-empty bit, receive request follows buffer-full bit.
// - Both requests are active high and driven straight from their status bits.
// - Synchronous coding is NRZ by default, NRZI both ways when selected.
// - NRZ sends a one as high level and a zero as low.
// - NRZI keeps the level for a one, toggles for a zero; receiver likewise.
// - Pattern bit set in sync mode: send the 511-bit pattern and detect it.
// - HDLC frame check is CRC-16 by default, CRC-32 when selected.
package modem_buffer_pkg;

	// ----------------------------------------
	// Buffer sizing
	// ----------------------------------------
	localparam int         FIFO_DEPTH = 16;
	localparam int         COUNT_W    = 5;
	localparam int         BYTE_W     = 8;
	localparam logic [4:0] FULL_CAP   = 5'h10;
	localparam logic [4:0] SINGLE_CAP = 5'h01;
	localparam logic [4:0] HALF_LEVEL = 5'h08;

	// ----------------------------------------
	// Serial side
	// ----------------------------------------
	localparam logic [2:0] LAST_BIT       = 3'h7;
	localparam logic [8:0] PRBS_SEED      = 9'h1ff;
	localparam logic [9:0] PATTERN_PERIOD = 10'h1ff;
	localparam logic       MARK_LEVEL     = 1'b1;

	// ----------------------------------------
	// Frame check
	// ----------------------------------------
	localparam logic [31:0] CRC16_POLY = 32'h00008408;
	localparam logic [31:0] CRC32_POLY = 32'hedb88320;
	localparam logic [31:0] CRC16_INIT = 32'h0000ffff;
	localparam logic [31:0] CRC32_INIT = 32'hffffffff;
	localparam logic [31:0] CRC16_GOOD = 32'h0000f0b8;
	localparam logic [31:0] CRC32_GOOD = 32'hdebb20e3;
	localparam logic [31:0] CRC16_MASK = 32'h0000ffff;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic [31:0] crc_init(input logic wide);
		crc_init = wide ? CRC32_INIT : CRC16_INIT;
	endfunction

	// One reflected bit step; CRC-16 keeps the upper half at zero
	function automatic logic [31:0] crc_step(input logic [31:0] crc, input logic data_bit, input logic wide);
		logic [31:0] poly;
		poly     = wide ? CRC32_POLY : CRC16_POLY;
		crc_step = {1'b0, crc[31:1]} ^ ((crc[0] ^ data_bit) ? poly : 32'h00000000);
	endfunction

	function automatic logic prbs_next(input logic [8:0] s);
		prbs_next = s[8] ^ s[4];
	endfunction

endpackage

// File: verilog/modem_byte_fifo.sv
// Byte FIFO with a run-time capacity limit, storage in flip-flops
module modem_byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int CNT_W = 5
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Fill side
	input  wire logic             wr_en,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic [CNT_W-1:0] limit,
	// Drain side
	input  wire logic             rd_en,
	output logic      [WIDTH-1:0] head,
	output logic      [CNT_W-1:0] count
);
	localparam int PTR_W = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [WIDTH-1:0] nxt_mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr_ff;
	logic [PTR_W-1:0] rd_ptr_ff;
	logic [PTR_W-1:0] nxt_wr_ptr;
	logic [PTR_W-1:0] nxt_rd_ptr;
	logic [CNT_W-1:0] count_ff;
	logic [CNT_W-1:0] nxt_count;
	logic             do_wr;
	logic             do_rd;

	function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
		bump = (int'(p) == DEPTH - 1) ? '0 : p + 1'b1;
	endfunction

	assign head  = mem_ff[rd_ptr_ff];
	assign count = count_ff;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		// A write beyond the limit is refused; a read of an empty buffer is ignored
		do_wr      = wr_en && (count_ff < limit);
		do_rd      = rd_en && (count_ff != '0);
		nxt_mem    = mem_ff;
		nxt_wr_ptr = wr_ptr_ff;
		nxt_rd_ptr = rd_ptr_ff;
		nxt_count  = count_ff;
		if (do_wr) begin
			nxt_mem[wr_ptr_ff] = wr_data;
			nxt_wr_ptr         = bump(wr_ptr_ff);
		end
		if (do_rd) begin
			nxt_rd_ptr = bump(rd_ptr_ff);
		end
		if (do_wr && !do_rd) begin
			nxt_count = count_ff + 1'b1;
		end else if (do_rd && !do_wr) begin
			nxt_count = count_ff - 1'b1;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_ff[i] <= '0;
			end
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end else begin
			mem_ff    <= nxt_mem;
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
			count_ff  <= nxt_count;
		end
	end

endmodule // modem_byte_fifo

// File: bench/modem_host_buffer_assertions.sv
// Port-level assertions for the modem host buffer
module modem_host_buffer_checker (
	// Clock and reset
	input wire logic       CLK,
	input wire logic       RST,
	// Configuration and host side
	input wire logic       SYNC_MODE,
	input wire logic       DMA_ENABLE,
	input wire logic       TX_BUFFER_ENABLE,
	input wire logic       TEST_PATTERN_ENABLE,
	input wire logic [3:0] INT_MASK,
	input wire logic       RX_RD_EN,
	input wire logic       RX_RD_VALID,
	// Status
	input wire logic       TX_NOT_FULL,
	input wire logic       RX_NOT_EMPTY,
	input wire logic       TX_HALF_FULL,
	input wire logic       RX_HALF_FULL,
	input wire logic       TX_BUFFER_EMPTY,
	input wire logic       RX_BUFFER_FULL,
	input wire logic       IRQ_REQUEST,
	// Pins and line
	input wire logic       RING_LEVEL_N,
	input wire logic       RING_INDICATOR_OUT,
	input wire logic       DATA_SET_READY_OUT,
	input wire logic       BIT_TICK,
	input wire logic       TX_LINE,
	input wire logic       PATTERN_DETECT
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	// ----------------------------------------
	// Masked flag change tracker
	// ----------------------------------------
	logic [3:0] flags;
	logic [3:0] flags_ff;
	logic       hit;
	assign flags = {TX_HALF_FULL, RX_HALF_FULL, RX_NOT_EMPTY, TX_NOT_FULL};
	assign hit   = |(INT_MASK & (flags ^ flags_ff));
	always_ff @(posedge CLK or posedge RST) begin
		if (RST)
			flags_ff <= 4'h1;
		else
			flags_ff <= flags;
	end
	property p_rx_half; RX_HALF_FULL |-> RX_NOT_EMPTY; endproperty
	a_rx_half: assert property (p_rx_half) else $error("rx half full without data");
	property p_tx_dma_request; (SYNC_MODE && DMA_ENABLE)[*3] |-> RING_INDICATOR_OUT == TX_BUFFER_EMPTY; endproperty
	a_tx_dma_request: assert property (p_tx_dma_request) else $error("tx request pin differs from empty bit");
	property p_rx_dma_request; (SYNC_MODE && DMA_ENABLE)[*3] |-> DATA_SET_READY_OUT == RX_BUFFER_FULL; endproperty
	a_rx_dma_request: assert property (p_rx_dma_request) else $error("rx request pin differs from full bit");
	property p_pins; (!(SYNC_MODE && DMA_ENABLE) && $stable(RING_LEVEL_N))[*5] |-> RING_INDICATOR_OUT == RING_LEVEL_N; endproperty
	a_pins: assert property (p_pins) else $error("ring pin not passed through");
	property p_irq_on; hit |-> ##[0:1] IRQ_REQUEST; endproperty
	a_irq_on: assert property (p_irq_on) else $error("masked flag change without request");
	property p_irq_off; IRQ_REQUEST |-> hit || $past(hit); endproperty
	a_irq_off: assert property (p_irq_off) else $error("request without masked flag change");
	property p_pattern; $rose(PATTERN_DETECT) |-> $past(SYNC_MODE) && $past(TEST_PATTERN_ENABLE); endproperty
	a_pattern: assert property (p_pattern) else $error("pattern detect outside pattern mode");
	property p_line; $changed(TX_LINE) |-> $past(BIT_TICK) || $past(BIT_TICK, 2); endproperty
	a_line: assert property (p_line) else $error("line moved without a bit tick");
	property p_cap; !TX_BUFFER_ENABLE && !TX_HALF_FULL |=> !TX_HALF_FULL; endproperty
	a_cap: assert property (p_cap) else $error("tx buffer grew while disabled");
	property p_valid; RX_RD_VALID |-> $past(RX_RD_EN); endproperty
	a_valid: assert property (p_valid) else $error("read answer without request");
	c_full: cover property (!TX_NOT_FULL);
	c_detect: cover property ($rose(PATTERN_DETECT));
	c_irq: cover property (IRQ_REQUEST);
endmodule // modem_host_buffer_checker

bind modem_host_buffer modem_host_buffer_checker u_modem_host_buffer_checker (
	.CLK(CLK), .RST(RST), .SYNC_MODE(SYNC_MODE), .DMA_ENABLE(DMA_ENABLE), .TX_BUFFER_ENABLE(TX_BUFFER_ENABLE),
	.TEST_PATTERN_ENABLE(TEST_PATTERN_ENABLE), .INT_MASK(INT_MASK), .RX_RD_EN(RX_RD_EN), .RX_RD_VALID(RX_RD_VALID),
	.TX_NOT_FULL(TX_NOT_FULL), .RX_NOT_EMPTY(RX_NOT_EMPTY), .TX_HALF_FULL(TX_HALF_FULL), .RX_HALF_FULL(RX_HALF_FULL),
	.TX_BUFFER_EMPTY(TX_BUFFER_EMPTY), .RX_BUFFER_FULL(RX_BUFFER_FULL), .IRQ_REQUEST(IRQ_REQUEST),
	.RING_LEVEL_N(RING_LEVEL_N), .RING_INDICATOR_OUT(RING_INDICATOR_OUT), .DATA_SET_READY_OUT(DATA_SET_READY_OUT),
	.BIT_TICK(BIT_TICK), .TX_LINE(TX_LINE), .PATTERN_DETECT(PATTERN_DETECT));

// File: bench/host_model.sv
// Host processor and DMA model moving bytes on the buffer requests
module host_model (
	// Clock
	input  wire logic       clk,
	// Requests and read answer
	input  wire logic       tx_req,
	input  wire logic       rx_req,
	input  wire logic       rd_valid,
	input  wire logic [7:0] rd_data,
	// Host strobes
	output logic            wr_en,
	output logic      [7:0] wr_data,
	output logic            rd_en
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		wr_en   = 1'b0;
		wr_data = 8'h5a;
		rd_en   = 1'b0;
	end
	// Released data shows the inverse so a stale byte is never mistaken
	task automatic write_byte(input logic [7:0] d, output logic ok);
		ok = 1'b0;
		for (int i = 0; i < 20 && !tx_req; i++) @(negedge clk);
		if (tx_req) begin
			ok      = 1'b1;
			wr_en   = 1'b1;
			wr_data = d;
			@(negedge clk);
			wr_en   = 1'b0;
			wr_data = ~d;
			repeat (2) @(negedge clk);
		end
	endtask
	task automatic read_byte(output logic [7:0] d, output logic ok);
		ok = 1'b0;
		d  = 8'h00;
		for (int i = 0; i < 20 && !rx_req; i++) @(negedge clk);
		if (rx_req) begin
			rd_en = 1'b1;
			@(negedge clk);
			// Valid stands for one cycle only, so the answer is taken here
			rd_en = 1'b0;
			d  = rd_data;
			ok = rd_valid;
			repeat (3) @(negedge clk);
		end
	endtask
endmodule // host_model

// File: bench/testbench.sv
// Self-checking bench for the modem host buffer block
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import modem_buffer_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk, rst, sync_mode, tx_en, dma_en, nrzi, pat_en, hdlc, crc32, crc_rst, tick, ring_n, dsr_n, rx_drv, loop_en;
	logic tx_wr_en, rx_rd_en, rx_rd_valid, tx_not_full, rx_not_empty, tx_half_full, rx_half_full, tx_empty, rx_full;
	logic ring_out, dsr_out, tx_line, rx_line, pattern_detect, ok, lvl, irq, crc_good;
	logic [3:0]  int_mask;
	logic [7:0]  tx_wr_data, rx_rd_data, d;
	logic [7:0]  bytes [16];
	logic [31:0] tx_fcs, crc;
	int          seed, err_total, check_count, i, b, irq_cnt, irq_base;
	assign rx_line = loop_en ? tx_line : rx_drv;
	always #50 clk = ~clk;
	// Counts interrupt pulses
	always @(posedge clk) begin
		irq_cnt <= irq_cnt + int'(irq);
	end
	modem_host_buffer u_modem_host_buffer (
		.CLK(clk), .RST(rst), .SYNC_MODE(sync_mode), .TX_BUFFER_ENABLE(tx_en), .DMA_ENABLE(dma_en),
		.INVERTED_CODING_SELECT(nrzi), .TEST_PATTERN_ENABLE(pat_en), .HDLC_MODE(hdlc), .CRC32_SELECT(crc32),
		.CRC_RESTART(crc_rst), .INT_MASK(int_mask), .TX_WR_EN(tx_wr_en), .TX_WR_DATA(tx_wr_data),
		.RX_RD_EN(rx_rd_en), .RX_RD_DATA(rx_rd_data), .RX_RD_VALID(rx_rd_valid), .TX_NOT_FULL(tx_not_full),
		.RX_NOT_EMPTY(rx_not_empty), .TX_HALF_FULL(tx_half_full), .RX_HALF_FULL(rx_half_full),
		.TX_BUFFER_EMPTY(tx_empty), .RX_BUFFER_FULL(rx_full), .IRQ_REQUEST(irq), .RING_LEVEL_N(ring_n),
		.DSR_LEVEL_N(dsr_n), .RING_INDICATOR_OUT(ring_out), .DATA_SET_READY_OUT(dsr_out), .BIT_TICK(tick),
		.TX_LINE(tx_line), .RX_LINE(rx_line), .PATTERN_DETECT(pattern_detect), .TX_FCS(tx_fcs),
		.RX_CRC_GOOD(crc_good));
	host_model u_host_model (.clk(clk), .tx_req(tx_empty), .rx_req(rx_full), .rd_valid(rx_rd_valid),
		.rd_data(rx_rd_data), .wr_en(tx_wr_en), .wr_data(tx_wr_data), .rd_en(rx_rd_en));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] crc_bit(input logic [31:0] c, input logic v, input logic w);
		return {1'b0, c[31:1]} ^ ((c[0] ^ v) ? (w ? CRC32_POLY : CRC16_POLY) : 32'h00000000);
	endfunction
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic need(input logic v);
		if (v !== 1'b1) begin
			err_total++;
			final_report();
		end
	endtask
	// Receive level is set well ahead of the tick to clear the input synchroniser
	task automatic send_bit(input logic v);
		rx_drv = v;
		repeat (3) @(negedge clk);
		tick = 1'b1;
		@(negedge clk);
		tick = 1'b0;
		repeat (3) @(negedge clk);
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		final_report();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{clk, rst, sync_mode, tx_en, dma_en, hdlc, ring_n, dsr_n, rx_drv} = 9'h0ff;
		{nrzi, pat_en, crc32, crc_rst, tick, loop_en, int_mask} = 10'h000;
		seed = 32'h7837;
		err_total = 0;
		check_count = 0;
		repeat (5) @(negedge clk);
		rst = 1'b0;
		check({tx_not_full, rx_not_empty, tx_half_full, rx_half_full, tx_line, pattern_detect}, 6'h22);
		int_mask = 4'($random(seed)) | 4'h1;
		for (i = 0; i < 16; i++) bytes[i] = 8'($random(seed));
		irq_base = irq_cnt;
		for (i = 0; i < 16; i++) begin
			u_host_model.write_byte(bytes[i], ok);
			need(ok);
			check({tx_half_full, tx_not_full, ring_out}, {i >= 7, i < 15, i < 15});
		end
		// Half full rises once and not full falls once during the fill
		check(irq_cnt - irq_base, 1 + int_mask[3]);
		u_host_model.write_byte(8'h00, ok);
		check(ok, 1'b0);
		crc_rst = 1'b1;
		@(negedge clk);
		crc_rst = 1'b0;
		crc = CRC16_INIT;
		lvl = 1'b1;
		for (i = 0; i < 16; i++) begin
			if (i == 8) begin
				check(tx_fcs, ~crc & CRC16_MASK);
				crc32 = 1'b1;
				crc_rst = 1'b1;
				@(negedge clk);
				crc_rst = 1'b0;
				crc = CRC32_INIT;
			end
			nrzi = i[0];
			for (b = 0; b < 8; b++) begin
				lvl = nrzi ? lvl ^ ~bytes[i][b] : bytes[i][b];
				crc = crc_bit(crc, bytes[i][b], crc32);
				send_bit(lvl);
				check(tx_line, lvl);
			end
			check({tx_half_full, rx_half_full, dsr_out}, {i < 8, i >= 7, 1'b1});
		end
		check(tx_fcs, ~crc);
		check(crc_good, 1'b0);
		// Frame check sent back into the receiver, coded NRZI, must leave the good residue
		for (b = 0; b < 32; b++) begin
			lvl = lvl ^ ~tx_fcs[b];
			send_bit(lvl);
		end
		check(crc_good, 1'b1);
		for (i = 0; i < 16; i++) begin
			u_host_model.read_byte(d, ok);
			need(ok);
			check(d, bytes[i]);
		end
		check({rx_not_empty, dsr_out}, 2'h0);
		{nrzi, loop_en, pat_en} = 3'h3;
		check(pattern_detect, 1'b0);
		repeat (600) send_bit(1'b1);
		check(pattern_detect, 1'b1);
		loop_en = 1'b0;
		repeat (20) send_bit(1'b1);
		check(pattern_detect, 1'b0);
		{pat_en, tx_en} = 2'h0;
		u_host_model.write_byte(bytes[0], ok);
		need(ok);
		check({tx_not_full, tx_half_full, ring_out}, 3'h0);
		for (i = 0; i < 4; i++) begin
			{sync_mode, dma_en} = i[1] ? 2'h2 : 2'h1;
			{ring_n, dsr_n} = 2'($random(seed));
			repeat (6) @(negedge clk);
			check({ring_out, dsr_out}, {ring_n, dsr_n});
		end
		final_report();
	end
endmodule // testbench
